// File: logic/port_alt_pkg.sv
// Purpose: constants and types for the port alternate function override block
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   package plus the per-pin control cell
package port_alt_pkg;
  localparam int          PORT_W        = 8;
  localparam logic [2:0]  SCK_BIT       = 3'h7;
  localparam logic [2:0]  MISO_BIT      = 3'h6;
  localparam logic [2:0]  MOSI_BIT      = 3'h5;
  localparam logic [2:0]  SEL_BIT       = 3'h4;
  localparam logic [2:0]  CMP_A_BIT     = 3'h3;
  localparam logic [2:0]  IRQ2_BIT      = 3'h2;
  localparam int          PB_FIRST_SRC  = 2;
  localparam logic        RST_VAL       = 1'h0;

  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic direction_override_en;
    logic direction_override_val;
    logic value_override_en;
    logic value_override_val;
    logic input_enable_override_en;
    logic input_enable_override_val;
  } override_t;

  localparam override_t NO_OVERRIDE = '0;
endpackage

`timescale 1ns/1ns
module pin_ctrl_cell
  import port_alt_pkg::*;
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_b_in,
  input  wire override_t ovr_in,
  input  wire logic      dir_bit_in,
  input  wire logic      out_bit_in,
  input  wire logic      global_pullup_disable_in,
  input  wire logic      sleep_in,
  input  wire logic      pad_in,
  output logic           pad_out,
  output logic           pad_oe_b_out,
  output logic           pullup_out,
  output logic           din_out
);
  logic sync1_q;
  logic sync2_q;
  logic din_q;
  logic drive_en;
  logic din_en;

  assign pullup_out   = ovr_in.pullup_override_en ? ovr_in.pullup_override_val
                      : (~dir_bit_in & out_bit_in & ~global_pullup_disable_in);
  assign drive_en     = ovr_in.direction_override_en ? ovr_in.direction_override_val : dir_bit_in;
  assign pad_oe_b_out = ~drive_en;
  assign pad_out      = ovr_in.value_override_en ? ovr_in.value_override_val : out_bit_in;
  assign din_en       = ovr_in.input_enable_override_en ? ovr_in.input_enable_override_val : ~sleep_in;
  assign din_out      = din_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      sync1_q <= RST_VAL;
      sync2_q <= RST_VAL;
      din_q   <= RST_VAL;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      din_q   <= sync2_q & din_en;
    end
  end
endmodule // pin_ctrl_cell

// File: logic/port_alt_function_override.sv
// Purpose: alternate function overrides for two 8-bit ports
// Assumes: port register bits and spi/timer controls come from same-clock logic
// Notes:   pad controls are combinational, digital inputs are synchronised
`timescale 1ns/1ns
module port_alt_function_override
  import port_alt_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              global_pullup_disable_in,
  input  wire logic              sleep_in,
  input  wire logic [PORT_W-1:0] porta_direction_bit_in,
  input  wire logic [PORT_W-1:0] porta_output_bit_in,
  input  wire logic [PORT_W-1:0] porta_pad_in,
  input  wire logic [PORT_W-1:0] port_a_change_mask_in,
  input  wire logic              change_group0_enable_in,
  input  wire logic [PORT_W-1:0] analog_digital_disable_bit_in,
  input  wire logic [PORT_W-1:0] portb_direction_bit_in,
  input  wire logic [PORT_W-1:0] portb_output_bit_in,
  input  wire logic [PORT_W-1:0] portb_pad_in,
  input  wire logic [PORT_W-1:0] port_b_change_mask_in,
  input  wire logic              change_group1_enable_in,
  input  wire logic              spi_enable_in,
  input  wire logic              spi_master_in,
  input  wire logic              spi_clock_drive_in,
  input  wire logic              spi_master_data_drive_in,
  input  wire logic              spi_slave_data_drive_in,
  input  wire logic              timer0_compare_a_en_in,
  input  wire logic              timer0_compare_a_out_in,
  input  wire logic              timer0_compare_b_en_in,
  input  wire logic              timer0_compare_b_out_in,
  input  wire logic              external_irq_2_en_in,
  output logic      [PORT_W-1:0] porta_pad_out,
  output logic      [PORT_W-1:0] porta_pad_oe_b_out,
  output logic      [PORT_W-1:0] porta_pullup_out,
  output logic      [PORT_W-1:0] portb_pad_out,
  output logic      [PORT_W-1:0] portb_pad_oe_b_out,
  output logic      [PORT_W-1:0] portb_pullup_out,
  output logic      [PORT_W-1:0] adc_channel_out,
  output logic    [2*PORT_W-1:0] pin_change_src_out,
  output logic                   external_irq_2_out,
  output logic                   comparator_pos_in_out,
  output logic                   comparator_neg_in_out,
  output logic                   spi_clock_in_out,
  output logic                   spi_master_data_in_out,
  output logic                   spi_slave_data_in_out,
  output logic                   spi_slave_select_b_out,
  output logic                   spi_slave_active_out
);
  override_t          ovr_a [PORT_W];
  override_t          ovr_b [PORT_W];
  logic  [PORT_W-1:0] din_a;
  logic  [PORT_W-1:0] din_b;
  logic  [PORT_W-1:0] chg_b;
  logic               spi_as_master;
  logic               spi_as_slave;

  assign spi_as_master = spi_enable_in & spi_master_in;
  assign spi_as_slave  = spi_enable_in & ~spi_master_in;
  assign chg_b         = port_b_change_mask_in & {PORT_W{change_group1_enable_in}};

  // port a: only the input enable is overridden
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_a
      logic chg;
      assign chg = port_a_change_mask_in[i] & change_group0_enable_in;
      always_comb begin
        ovr_a[i] = NO_OVERRIDE;
        ovr_a[i].input_enable_override_en  = chg | analog_digital_disable_bit_in[i];
        ovr_a[i].input_enable_override_val = chg;
      end
      pin_ctrl_cell u_cell (
        .sys_clk_in               (sys_clk_in),
        .rst_b_in                 (rst_b_in),
        .ovr_in                   (ovr_a[i]),
        .dir_bit_in               (porta_direction_bit_in[i]),
        .out_bit_in               (porta_output_bit_in[i]),
        .global_pullup_disable_in (global_pullup_disable_in),
        .sleep_in                 (sleep_in),
        .pad_in                   (porta_pad_in[i]),
        .pad_out                  (porta_pad_out[i]),
        .pad_oe_b_out             (porta_pad_oe_b_out[i]),
        .pullup_out               (porta_pullup_out[i]),
        .din_out                  (din_a[i])
      );
      pin_ctrl_cell u_cell_b (
        .sys_clk_in               (sys_clk_in),
        .rst_b_in                 (rst_b_in),
        .ovr_in                   (ovr_b[i]),
        .dir_bit_in               (portb_direction_bit_in[i]),
        .out_bit_in               (portb_output_bit_in[i]),
        .global_pullup_disable_in (global_pullup_disable_in),
        .sleep_in                 (sleep_in),
        .pad_in                   (portb_pad_in[i]),
        .pad_out                  (portb_pad_out[i]),
        .pad_oe_b_out             (portb_pad_oe_b_out[i]),
        .pullup_out               (portb_pullup_out[i]),
        .din_out                  (din_b[i])
      );
    end
  endgenerate

  // port b overrides per pin
  always_comb begin
    for (int k = 0; k < PORT_W; k++) begin
      ovr_b[k] = NO_OVERRIDE;
      if (k >= PB_FIRST_SRC) begin
        ovr_b[k].input_enable_override_en  = chg_b[k];
        ovr_b[k].input_enable_override_val = 1'h1;
      end
    end
    // serial clock: forced input as slave, driven clock as master
    ovr_b[SCK_BIT].pullup_override_en     = spi_as_slave;
    ovr_b[SCK_BIT].pullup_override_val    = portb_output_bit_in[SCK_BIT] & ~global_pullup_disable_in;
    ovr_b[SCK_BIT].direction_override_en  = spi_as_slave;
    ovr_b[SCK_BIT].value_override_en      = spi_as_master;
    ovr_b[SCK_BIT].value_override_val     = spi_clock_drive_in;
    // master-in/slave-out: forced input as master
    ovr_b[MISO_BIT].pullup_override_en    = spi_as_master;
    ovr_b[MISO_BIT].pullup_override_val   = portb_output_bit_in[MISO_BIT] & ~global_pullup_disable_in;
    ovr_b[MISO_BIT].direction_override_en = spi_as_master;
    ovr_b[MISO_BIT].value_override_en     = spi_as_slave;
    ovr_b[MISO_BIT].value_override_val    = spi_slave_data_drive_in;
    // master-out/slave-in: forced input as slave
    ovr_b[MOSI_BIT].pullup_override_en    = spi_as_slave;
    ovr_b[MOSI_BIT].pullup_override_val   = portb_output_bit_in[MOSI_BIT] & ~global_pullup_disable_in;
    ovr_b[MOSI_BIT].direction_override_en = spi_as_slave;
    ovr_b[MOSI_BIT].value_override_en     = spi_as_master;
    ovr_b[MOSI_BIT].value_override_val    = spi_master_data_drive_in;
    // slave select: forced input as slave, else compare b output
    ovr_b[SEL_BIT].pullup_override_en     = spi_as_slave;
    ovr_b[SEL_BIT].pullup_override_val    = portb_output_bit_in[SEL_BIT] & ~global_pullup_disable_in;
    ovr_b[SEL_BIT].direction_override_en  = spi_as_slave;
    ovr_b[SEL_BIT].value_override_en      = timer0_compare_b_en_in;
    ovr_b[SEL_BIT].value_override_val     = timer0_compare_b_out_in;
    // compare a; driver still follows the direction bit
    ovr_b[CMP_A_BIT].value_override_en    = timer0_compare_a_en_in;
    ovr_b[CMP_A_BIT].value_override_val   = timer0_compare_a_out_in;
    // external interrupt 2 keeps the input alive
    ovr_b[IRQ2_BIT].input_enable_override_en = chg_b[IRQ2_BIT] | external_irq_2_en_in;
  end

  assign adc_channel_out        = porta_pad_in;
  assign comparator_pos_in_out  = portb_pad_in[IRQ2_BIT];
  assign comparator_neg_in_out  = portb_pad_in[CMP_A_BIT];
  assign pin_change_src_out     = {din_b[PORT_W-1:PB_FIRST_SRC], {PB_FIRST_SRC{1'h0}}, din_a};
  assign external_irq_2_out     = din_b[IRQ2_BIT];
  assign spi_clock_in_out       = din_b[SCK_BIT];
  assign spi_master_data_in_out = din_b[MISO_BIT];
  assign spi_slave_data_in_out  = din_b[MOSI_BIT];
  assign spi_slave_select_b_out = din_b[SEL_BIT];
  assign spi_slave_active_out   = spi_as_slave & ~din_b[SEL_BIT];
endmodule // port_alt_function_override

// File: tb/pad_partner.sv
// Purpose: pad level model for both ports
// Assumes: external drivers always present
// Notes:   device wins where it drives
`timescale 1ns/1ns
module pad_partner
  import port_alt_pkg::*;
(
  input  wire logic [PORT_W-1:0] ext_a_in,
  input  wire logic [PORT_W-1:0] ext_b_in,
  input  wire logic [PORT_W-1:0] a_oe_b_in,
  input  wire logic [PORT_W-1:0] b_oe_b_in,
  input  wire logic [PORT_W-1:0] a_drv_in,
  input  wire logic [PORT_W-1:0] b_drv_in,
  output logic      [PORT_W-1:0] a_wire_out,
  output logic      [PORT_W-1:0] b_wire_out
);
  assign a_wire_out = (~a_oe_b_in & a_drv_in) | (a_oe_b_in & ext_a_in);
  // master pulls select low through ext_b_in bit 4
  assign b_wire_out = (~b_oe_b_in & b_drv_in) | (b_oe_b_in & ext_b_in);
endmodule // pad_partner

// File: tb/port_alt_chk.sv
// Purpose: port override checks
// Assumes: bound to the top module
// Notes:   pad controls combinational
`timescale 1ns/1ns
module port_alt_chk
  import port_alt_pkg::*;
(
  input wire logic                sys_clk_in,
  input wire logic                rst_b_in,
  input wire logic                spi_enable_in,
  input wire logic                spi_master_in,
  input wire logic                external_irq_2_en_in,
  input wire logic                timer0_compare_a_en_in,
  input wire logic                timer0_compare_a_out_in,
  input wire logic                timer0_compare_b_en_in,
  input wire logic                timer0_compare_b_out_in,
  input wire logic                external_irq_2_out,
  input wire logic                comparator_pos_in_out,
  input wire logic                comparator_neg_in_out,
  input wire logic [PORT_W-1:0]   porta_direction_bit_in,
  input wire logic [PORT_W-1:0]   porta_pad_in,
  input wire logic [PORT_W-1:0]   portb_direction_bit_in,
  input wire logic [PORT_W-1:0]   portb_pad_in,
  input wire logic [PORT_W-1:0]   porta_pad_oe_b_out,
  input wire logic [PORT_W-1:0]   portb_pad_oe_b_out,
  input wire logic [PORT_W-1:0]   portb_pad_out,
  input wire logic [PORT_W-1:0]   adc_channel_out,
  input wire logic [2*PORT_W-1:0] pin_change_src_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic slv = spi_enable_in && !spi_master_in;
  property p_pa_ctl; porta_pad_oe_b_out == ~porta_direction_bit_in; endproperty
  a_pa_ctl: assert property (p_pa_ctl) else $error("port a driver");
  property p_slv; slv |-> portb_pad_oe_b_out[7] && portb_pad_oe_b_out[5] && portb_pad_oe_b_out[4]; endproperty
  a_slv: assert property (p_slv) else $error("slave pins driven");
  property p_mst; spi_enable_in && spi_master_in |-> portb_pad_oe_b_out[6]
    && portb_pad_oe_b_out[7] == !portb_direction_bit_in[7]; endproperty
  a_mst: assert property (p_mst) else $error("master pins");
  property p_cmp_b; portb_direction_bit_in[4] && !spi_enable_in && timer0_compare_b_en_in
    |-> portb_pad_out[4] == timer0_compare_b_out_in && !portb_pad_oe_b_out[4]; endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare b");
  property p_cmp_a; timer0_compare_a_en_in |-> portb_pad_oe_b_out[3] == !portb_direction_bit_in[3]
    && (portb_pad_oe_b_out[3] || portb_pad_out[3] == timer0_compare_a_out_in); endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare a");
  property p_analog; adc_channel_out == porta_pad_in && comparator_pos_in_out == portb_pad_in[2]
    && comparator_neg_in_out == portb_pad_in[3]; endproperty
  a_analog: assert property (p_analog) else $error("analog path");
  property p_pair; pin_change_src_out[10:8] == {external_irq_2_out, 2'h0}; endproperty
  a_pair: assert property (p_pair) else $error("irq2 pair");
  property p_irq; ($rose(portb_pad_in[2]) ##0 (portb_pad_in[2] && external_irq_2_en_in)[*4])
    |-> external_irq_2_out; endproperty
  a_irq: assert property (p_irq) else $error("irq2 latency");
endmodule // port_alt_chk
bind port_alt_function_override port_alt_chk port_alt_chk_i (.*);

// File: tb/port_alt_function_override_tb.sv
// Purpose: random bench for port overrides
// Assumes: pads from pad_partner
// Notes:   vectors held four cycles
`timescale 1ns/1ns
module port_alt_function_override_tb;
  import port_alt_pkg::*;
  logic sys_clk_in, rst_b_in, global_pullup_disable_in, sleep_in, change_group0_enable_in, change_group1_enable_in;
  logic spi_enable_in, spi_master_in, spi_clock_drive_in, spi_master_data_drive_in, spi_slave_data_drive_in;
  logic timer0_compare_a_en_in, timer0_compare_a_out_in, timer0_compare_b_en_in, timer0_compare_b_out_in;
  logic external_irq_2_en_in, external_irq_2_out, comparator_pos_in_out, comparator_neg_in_out, slv, mst, pu;
  logic spi_clock_in_out, spi_master_data_in_out, spi_slave_data_in_out, spi_slave_select_b_out, spi_slave_active_out;
  logic [PORT_W-1:0] porta_direction_bit_in, porta_output_bit_in, porta_pad_in, port_a_change_mask_in, ext_a, ext_b;
  logic [PORT_W-1:0] analog_digital_disable_bit_in, portb_direction_bit_in, portb_output_bit_in, portb_pad_in;
  logic [PORT_W-1:0] port_b_change_mask_in, porta_pad_out, porta_pad_oe_b_out, porta_pullup_out, portb_pad_out;
  logic [PORT_W-1:0] portb_pad_oe_b_out, portb_pullup_out, adc_channel_out, ena, enb, frc, drv, pbv;
  logic [2*PORT_W-1:0] pin_change_src_out;
  logic [31:0] got_ctl;
  logic [25:0] got_in;
  logic [11:0] got_drv;
  logic [69:0] q[$];
  logic [69:0] nt;
  int mismatches, n_tests;
  event sample_ev;
  port_alt_function_override port_alt_function_override_i (.*);
  pad_partner pad_partner_i (.ext_a_in(ext_a), .ext_b_in(ext_b), .a_oe_b_in(porta_pad_oe_b_out),
    .b_oe_b_in(portb_pad_oe_b_out), .a_drv_in(porta_pad_out), .b_drv_in(portb_pad_out),
    .a_wire_out(porta_pad_in), .b_wire_out(portb_pad_in));
  assign got_ctl = {porta_pad_oe_b_out, porta_pullup_out, portb_pad_oe_b_out, portb_pullup_out};
  assign got_in  = {pin_change_src_out, external_irq_2_out, spi_slave_active_out, porta_pad_out & porta_direction_bit_in};
  assign got_drv = {spi_clock_in_out, spi_master_data_in_out, spi_slave_data_in_out, spi_slave_select_b_out,
                    portb_pad_out & drv};
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_ctl(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t ctl %h %h", $time, got, exp);
    end
  endtask
  task automatic cmp_in(input logic [25:0] got, input logic [25:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t in %h %h", $time, got, exp);
    end
  endtask
  task automatic cmp_drv(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t drv %h %h", $time, got, exp);
    end
  endtask
  initial begin
    sys_clk_in = 1'h0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    forever begin
      @(sample_ev);
      nt = q.pop_front();
      cmp_ctl(got_ctl, nt[69:38]);
      cmp_in(got_in, nt[37:12]);
      cmp_drv(got_drv, nt[11:0]);
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    mismatches++;
    report_and_stop;
  end
  initial begin
    rst_b_in = 1'h0;
    {global_pullup_disable_in, sleep_in, change_group0_enable_in, change_group1_enable_in, spi_enable_in,
      spi_master_in, spi_clock_drive_in, spi_master_data_drive_in, spi_slave_data_drive_in, timer0_compare_a_en_in,
      timer0_compare_a_out_in, timer0_compare_b_en_in, timer0_compare_b_out_in, external_irq_2_en_in} = 14'h0;
    {porta_direction_bit_in, porta_output_bit_in, port_a_change_mask_in, analog_digital_disable_bit_in} = 32'h0;
    {portb_direction_bit_in, portb_output_bit_in, port_b_change_mask_in, ext_a, ext_b} = 40'h0;
    void'($urandom(32'h0c395473));
    repeat (5) @(negedge sys_clk_in);
    rst_b_in = 1'h1;
    for (int k = 0; k < 300; k++) begin
      {global_pullup_disable_in, sleep_in, change_group0_enable_in, change_group1_enable_in, spi_enable_in,
        spi_master_in, spi_clock_drive_in, spi_master_data_drive_in, spi_slave_data_drive_in, timer0_compare_a_en_in,
        timer0_compare_a_out_in, timer0_compare_b_en_in, timer0_compare_b_out_in, external_irq_2_en_in} = 14'($urandom);
      {porta_direction_bit_in, porta_output_bit_in, port_a_change_mask_in, analog_digital_disable_bit_in} = $urandom;
      {portb_direction_bit_in, portb_output_bit_in, port_b_change_mask_in, ext_a} = $urandom;
      ext_b = 8'($urandom);
      repeat (3) @(negedge sys_clk_in);
      slv = spi_enable_in & ~spi_master_in;
      mst = spi_enable_in & spi_master_in;
      pu = ~global_pullup_disable_in;
      frc = {slv, mst, slv, slv, 4'h0};
      drv = portb_direction_bit_in & ~frc;
      pbv = {mst ? spi_clock_drive_in : portb_output_bit_in[7], slv ? spi_slave_data_drive_in : portb_output_bit_in[6],
        mst ? spi_master_data_drive_in : portb_output_bit_in[5],
        timer0_compare_b_en_in ? timer0_compare_b_out_in : portb_output_bit_in[4],
        timer0_compare_a_en_in ? timer0_compare_a_out_in : portb_output_bit_in[3], portb_output_bit_in[2:0]};
      ena = (port_a_change_mask_in & {8{change_group0_enable_in}}) | (~analog_digital_disable_bit_in & {8{~sleep_in}});
      enb = (port_b_change_mask_in & {8{change_group1_enable_in}}) | {5'h0, external_irq_2_en_in, 2'h0} | {8{~sleep_in}};
      q.push_back({~porta_direction_bit_in, ~porta_direction_bit_in & porta_output_bit_in & {8{pu}},
        ~portb_direction_bit_in | frc, portb_output_bit_in & {8{pu}} & (~portb_direction_bit_in | frc),
        portb_pad_in[7:2] & enb[7:2], 2'h0, porta_pad_in & ena, portb_pad_in[2] & enb[2],
        slv & ~(portb_pad_in[4] & enb[4]), porta_output_bit_in & porta_direction_bit_in,
        portb_pad_in[7:4] & enb[7:4], pbv & drv});
      -> sample_ev;
      @(negedge sys_clk_in);
    end
    repeat (2) @(negedge sys_clk_in);
    report_and_stop;
  end
endmodule // port_alt_function_override_tb
